// File: core/crc_consts.svh
// constants shared by both ends of the crc engine link
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CRC_ADDR_OPER       8'hef
`define CRC_ADDR_INX        8'hfc
`define CRC_ADDR_DATA       8'hfd
`define CRC_OPER_START      0
`define CRC_OPER_PRESET     1
`define CRC_BYTE_SEL_W      2

// ----------------------------------------
// crc model
// ----------------------------------------
`define CRC_POLY            32'h04c11db7
`define CRC_INIT            32'hffffffff
`define CRC_BITS_PER_BYTE   8

// ----------------------------------------
// flash and scan range
// ----------------------------------------
`define CRC_FLASH_BYTES     32768
`define CRC_FLASH_AW        15
`define CRC_KBYTE           1024
`define CRC_REGION_NONE     2'h0
`define CRC_REGION_1K       2'h1
`define CRC_REGION_2K       2'h2
`define CRC_REGION_ALL      2'h3

// ----------------------------------------
// buffering and timing
// ----------------------------------------
`define CRC_FIFO_DEPTH      32
`define CRC_CLK_MHZ         125
`define CRC_BYTE_TIME_NS    250
`define CRC_BYTE_MAX_CYC    ((`CRC_BYTE_TIME_NS * `CRC_CLK_MHZ) / 1000)
`define CRC_SCAN_TIME_US    8300
`define CRC_SCAN_MAX_CYC    (`CRC_SCAN_TIME_US * `CRC_CLK_MHZ)
`define CRC_NOP_GAP         4'h8

`endif

// File: core/crc_pkg.sv
// types shared by both ends of the crc engine link
package crc_pkg;

  typedef enum logic [1:0] {
    CRC_SCAN_IDLE  = 2'h0,
    CRC_SCAN_REQ   = 2'h1,
    CRC_SCAN_WAIT  = 2'h2,
    CRC_SCAN_DRAIN = 2'h3
  } crc_scan_st_t;

  typedef enum logic [0:0] {
    CRC_HOST_IDLE = 1'h0,
    CRC_HOST_RD   = 1'h1
  } crc_host_st_t;

endpackage

// File: core/crc_if.sv
// link between processor/flash end and crc engine end
`timescale 1ns/1ps
`include "crc_consts.svh"

interface crc_if #(
  parameter int FAW = `CRC_FLASH_AW
);
  logic           sfr_wr;
  logic           sfr_rd;
  logic [7:0]     sfr_addr;
  logic [7:0]     sfr_wdata;
  logic [7:0]     sfr_rdata;
  logic           sfr_rd_valid;
  logic           data_ready;
  logic           cpu_hold;
  logic           boot_exec;
  logic [1:0]     region_size;
  logic           fl_rd;
  logic [FAW-1:0] fl_addr;
  logic [7:0]     fl_data;
  logic           fl_valid;

  modport dev (
    input  sfr_wr, sfr_rd, sfr_addr, sfr_wdata, boot_exec, region_size, fl_data, fl_valid,
    output sfr_rdata, sfr_rd_valid, data_ready, cpu_hold, fl_rd, fl_addr
  );

  modport host (
    output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, boot_exec, region_size, fl_data, fl_valid,
    input  sfr_rdata, sfr_rd_valid, data_ready, cpu_hold, fl_rd, fl_addr
  );
endinterface // crc_if

// File: core/crc_dev.sv
// crc engine end: byte fifo and crc engine with program-scan sequencer
`timescale 1ns/1ps
`include "crc_consts.svh"

// ----------------------------------------
// byte fifo
// ----------------------------------------
module crc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = `CRC_FIFO_DEPTH
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rstn_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    full;
    logic                    nempty;
  } crc_fifo_state_t;

  crc_fifo_state_t q;
  crc_fifo_state_t d;
  logic            push;
  logic            pop;

  always_comb begin
    d    = q;
    push = in_valid_in && !q.full;
    pop  = out_ready_in && q.nempty;
    if (push) begin
      d.mem[q.wp] = in_data_in;
      d.wp        = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    case ({push, pop})
      2'h2:    d.cnt = q.cnt + 1'b1;
      2'h1:    d.cnt = q.cnt - 1'b1;
      default: d.cnt = q.cnt;
    endcase
    d.full   = (d.cnt == FULL_CNT);
    d.nempty = (d.cnt != '0);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign in_ready_out  = !q.full;
  assign out_valid_out = q.nempty;
  assign out_data_out  = q.mem[q.rp];
endmodule // crc_fifo

// ----------------------------------------
// crc engine
// ----------------------------------------
module crc_dev #(
  parameter int FLASH_BYTES  = `CRC_FLASH_BYTES,
  parameter int SCAN_MAX_CYC = `CRC_SCAN_MAX_CYC
) (
  input  wire logic  sys_clk_in,
  input  wire logic  rstn_in,
  crc_if.dev         bus,
  output logic [31:0] crc_value_out,
  output logic        scan_busy_out
);
  localparam int FAW = $clog2(FLASH_BYTES);
  localparam logic [FAW:0] END_FULL = (FAW+1)'(FLASH_BYTES);
  localparam logic [FAW:0] END_1K   = (FAW+1)'(FLASH_BYTES - `CRC_KBYTE);
  localparam logic [FAW:0] END_2K   = (FAW+1)'(FLASH_BYTES - 2 * `CRC_KBYTE);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  generate
    if (`CRC_BITS_PER_BYTE > `CRC_BYTE_MAX_CYC) begin : g_bad_byte_time
      $error("byte processing cannot meet its time bound at this clock");
    end
    // any size above the largest excluded area that also meets the scan time bound works; the end compare needs no power of two
    if (FLASH_BYTES <= 2 * `CRC_KBYTE) begin : g_bad_flash
      $error("flash size must be above 2 KiB");
    end
    if (FLASH_BYTES * (`CRC_BITS_PER_BYTE + 1) > SCAN_MAX_CYC) begin : g_bad_scan_time
      $error("scan cannot meet its time bound at this clock");
    end
  endgenerate

  typedef struct packed {
    crc_pkg::crc_scan_st_t st;
    logic [31:0]           crc;
    logic [7:0]            sh;
    logic [2:0]            bits;
    logic                  busy;
    logic [`CRC_BYTE_SEL_W-1:0] idx;
    logic [FAW-1:0]        addr;
    logic [FAW:0]          last;
    logic                  fl_rd;
    logic [7:0]            rdata;
    logic                  rd_valid;
    logic                  hold;
  } crc_dev_state_t;

  localparam crc_dev_state_t RST = '{st: crc_pkg::CRC_SCAN_IDLE, crc: `CRC_INIT, default: '0};

  crc_dev_state_t q;
  crc_dev_state_t d;
  logic           push;
  logic [7:0]     push_data;
  logic           f_in_ready;
  logic           f_out_valid;
  logic [7:0]     f_out_data;
  logic           fb;
  logic [FAW:0]   scan_end;

  // ----------------------------------------
  // input buffer shared by byte writes and flash fetches
  // ----------------------------------------
  crc_fifo #(
    .W     (8),
    .DEPTH (`CRC_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (push),
    .in_ready_out  (f_in_ready),
    .in_data_in    (push_data),
    .out_valid_out (f_out_valid),
    .out_ready_in  (!q.busy),
    .out_data_out  (f_out_data)
  );

  always_comb begin
    case (bus.region_size)
      `CRC_REGION_1K: scan_end = END_1K;
      `CRC_REGION_2K: scan_end = END_2K;
      default:        scan_end = END_FULL;
    endcase
  end

  always_comb begin
    d           = q;
    d.rd_valid  = 1'b0;
    d.fl_rd     = 1'b0;
    push        = 1'b0;
    push_data   = bus.sfr_wdata;
    fb          = q.crc[31] ^ q.sh[7];

    // ----------------------------------------
    // bit-serial engine, one bit per clock
    // ----------------------------------------
    if (q.busy) begin
      d.crc  = {q.crc[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h00000000);
      d.sh   = {q.sh[6:0], 1'b0};
      d.bits = q.bits + 3'h1;
      if (q.bits == 3'(`CRC_BITS_PER_BYTE - 1)) begin
        d.busy = 1'b0;
      end
    end else if (f_out_valid) begin
      d.busy = 1'b1;
      d.sh   = f_out_data;
      d.bits = 3'h0;
    end

    // ----------------------------------------
    // program scan sequencer
    // ----------------------------------------
    case (q.st)
      crc_pkg::CRC_SCAN_IDLE: begin
      end
      crc_pkg::CRC_SCAN_REQ: begin
        // one fetch in flight; space checked here so the push cannot be lost
        if (f_in_ready) begin
          d.fl_rd = 1'b1;
          d.st    = crc_pkg::CRC_SCAN_WAIT;
        end
      end
      crc_pkg::CRC_SCAN_WAIT: begin
        if (bus.fl_valid) begin
          push      = 1'b1;
          push_data = bus.fl_data;
          d.addr    = q.addr + 1'b1;
          if (({1'b0, q.addr} + 1'b1) == q.last) begin
            d.st = crc_pkg::CRC_SCAN_DRAIN;
          end else begin
            d.st = crc_pkg::CRC_SCAN_REQ;
          end
        end
      end
      crc_pkg::CRC_SCAN_DRAIN: begin
        if (!f_out_valid && !q.busy) begin
          d.st = crc_pkg::CRC_SCAN_IDLE;
        end
      end
      default: d.st = crc_pkg::CRC_SCAN_IDLE;
    endcase

    // ----------------------------------------
    // register writes; later assignments win over the engine step
    // ----------------------------------------
    if (bus.sfr_wr) begin
      case (bus.sfr_addr)
        `CRC_ADDR_OPER: begin
          if (bus.sfr_wdata[`CRC_OPER_PRESET]) begin
            d.crc = `CRC_INIT;
          end
          // start from the boot loader is dropped, scan would be meaningless
          if (bus.sfr_wdata[`CRC_OPER_START] && !bus.boot_exec && q.st == crc_pkg::CRC_SCAN_IDLE) begin
            d.crc  = `CRC_INIT;
            d.st   = crc_pkg::CRC_SCAN_REQ;
            d.addr = '0;
            d.last = scan_end;
          end
        end
        `CRC_ADDR_INX:  d.idx = bus.sfr_wdata[`CRC_BYTE_SEL_W-1:0];
        `CRC_ADDR_DATA: push  = 1'b1;
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    if (bus.sfr_rd) begin
      d.rd_valid = 1'b1;
      case (bus.sfr_addr)
        `CRC_ADDR_DATA: begin
          d.rdata = q.crc[8*q.idx +: 8];
          d.idx   = q.idx + 1'b1;
        end
        `CRC_ADDR_INX:  d.rdata = {6'h00, q.idx};
        `CRC_ADDR_OPER: d.rdata = {7'h00, q.st != crc_pkg::CRC_SCAN_IDLE};
        default:        d.rdata = 8'h00;
      endcase
    end

    d.hold = (d.st != crc_pkg::CRC_SCAN_IDLE) || d.busy || push || f_out_valid;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign bus.sfr_rdata    = q.rdata;
  assign bus.sfr_rd_valid = q.rd_valid;
  assign bus.data_ready   = f_in_ready;
  assign bus.cpu_hold     = q.hold;
  assign bus.fl_rd        = q.fl_rd;
  assign bus.fl_addr      = q.addr;
  assign crc_value_out    = q.crc;
  assign scan_busy_out    = (q.st != crc_pkg::CRC_SCAN_IDLE);
endmodule // crc_dev

// File: core/crc_host.sv
// processor and flash end of the crc engine link
`timescale 1ns/1ps
`include "crc_consts.svh"

module crc_host #(
  parameter int FAW = `CRC_FLASH_AW
) (
  input  wire logic           sys_clk_in,
  input  wire logic           rstn_in,
  crc_if.host                 bus,
  input  wire logic           cmd_valid_in,
  input  wire logic           cmd_write_in,
  input  wire logic [7:0]     cmd_addr_in,
  input  wire logic [7:0]     cmd_wdata_in,
  output logic                cmd_ready_out,
  output logic                rsp_valid_out,
  output logic [7:0]          rsp_data_out,
  input  wire logic           boot_exec_in,
  input  wire logic [1:0]     region_size_in,
  output logic [FAW-1:0]      fl_addr_out,
  input  wire logic [7:0]     fl_rdata_in,
  input  wire logic [31:0]    ref_crc_in,
  output logic [31:0]         result_word_out,
  output logic                result_match_out,
  output logic                global_irq_enable_out,
  output logic                held_out
);
  generate
    if (FAW < 12) begin : g_bad_faw
      $error("flash address width too small");
    end
  endgenerate

  typedef struct packed {
    crc_pkg::crc_host_st_t st;
    logic                  wr;
    logic                  rd;
    logic [7:0]            addr;
    logic [7:0]            wdata;
    logic                  ready;
    logic                  rsp_valid;
    logic [7:0]            rsp_data;
    logic                  boot;
    logic [1:0]            region;
    logic [FAW-1:0]        fl_addr;
    logic                  fl_pend;
    logic                  fl_valid;
    logic [7:0]            fl_data;
    logic [3:0]            gap;
    logic                  irq_en;
    logic [31:0]           word;
    logic                  match;
    logic                  held;
  } crc_host_state_t;

  crc_host_state_t q;
  crc_host_state_t d;
  logic            take;
  logic            kick;

  always_comb begin
    d           = q;
    d.wr        = 1'b0;
    d.rd        = 1'b0;
    d.rsp_valid = 1'b0;
    d.fl_valid  = 1'b0;
    d.boot      = boot_exec_in;
    d.region    = region_size_in;
    d.held      = bus.cpu_hold;
    take        = cmd_valid_in && q.ready && (q.st == crc_pkg::CRC_HOST_IDLE);
    kick        = take && cmd_write_in &&
                  (cmd_addr_in == `CRC_ADDR_DATA ||
                   (cmd_addr_in == `CRC_ADDR_OPER && cmd_wdata_in[`CRC_OPER_START]));

    // ----------------------------------------
    // flash array port, data one clock after the address
    // ----------------------------------------
    if (bus.fl_rd) begin
      d.fl_addr = bus.fl_addr;
      d.fl_pend = 1'b1;
    end
    if (q.fl_pend) begin
      d.fl_data  = fl_rdata_in;
      d.fl_valid = 1'b1;
      d.fl_pend  = 1'b0;
    end

    // ----------------------------------------
    // register access sequencer
    // ----------------------------------------
    case (q.st)
      crc_pkg::CRC_HOST_IDLE: begin
        if (take) begin
          d.wr    = cmd_write_in;
          d.rd    = !cmd_write_in;
          d.addr  = cmd_addr_in;
          d.wdata = cmd_wdata_in;
          if (!cmd_write_in) begin
            d.st = crc_pkg::CRC_HOST_RD;
          end
        end
      end
      crc_pkg::CRC_HOST_RD: begin
        if (bus.sfr_rd_valid) begin
          d.rsp_valid = 1'b1;
          d.rsp_data  = bus.sfr_rdata;
          d.st        = crc_pkg::CRC_HOST_IDLE;
          if (q.addr == `CRC_ADDR_DATA) begin
            d.word = {bus.sfr_rdata, q.word[31:8]};
          end
        end
      end
      default: d.st = crc_pkg::CRC_HOST_IDLE;
    endcase

    // nop gap after a start or data write, interrupts masked meanwhile
    if (kick) begin
      d.gap = `CRC_NOP_GAP;
    end else if (q.gap != 4'h0) begin
      d.gap = q.gap - 4'h1;
    end
    d.irq_en = (d.gap == 4'h0) && !kick;
    d.match  = (d.word == ref_crc_in);

    // no access issued while held, nor in the clock after an issue
    d.ready = (d.st == crc_pkg::CRC_HOST_IDLE) && !take && !q.wr && !q.rd &&
              !bus.cpu_hold && bus.data_ready && (d.gap == 4'h0);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.sfr_wr         = q.wr;
  assign bus.sfr_rd         = q.rd;
  assign bus.sfr_addr       = q.addr;
  assign bus.sfr_wdata      = q.wdata;
  assign bus.boot_exec      = q.boot;
  assign bus.region_size    = q.region;
  assign bus.fl_data        = q.fl_data;
  assign bus.fl_valid       = q.fl_valid;
  assign cmd_ready_out      = q.ready;
  assign rsp_valid_out      = q.rsp_valid;
  assign rsp_data_out       = q.rsp_data;
  assign fl_addr_out        = q.fl_addr;
  assign result_word_out    = q.word;
  assign result_match_out   = q.match;
  assign global_irq_enable_out = q.irq_en;
  assign held_out           = q.held;
endmodule // crc_host

// File: bench/crc_link_props.sv
// concurrent checks on the link between the host end and the crc engine end
`timescale 1ns/1ps
`include "crc_consts.svh"

module crc_link_props #(
  parameter int FAW         = `CRC_FLASH_AW,
  parameter int FLASH_BYTES = `CRC_FLASH_BYTES
) (
  input wire logic           sys_clk_in,
  input wire logic           rstn_in,
  input wire logic           sfr_wr,
  input wire logic           sfr_rd,
  input wire logic [7:0]     sfr_addr,
  input wire logic [7:0]     sfr_wdata,
  input wire logic           sfr_rd_valid,
  input wire logic           cpu_hold,
  input wire logic           boot_exec,
  input wire logic [1:0]     region_size,
  input wire logic           fl_rd,
  input wire logic [FAW-1:0] fl_addr,
  input wire logic           fl_valid
);
  logic         wr_data;
  logic         start;
  logic [FAW:0] scan_lim;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always_comb begin
    wr_data  = sfr_wr && sfr_addr == `CRC_ADDR_DATA;
    start    = sfr_wr && sfr_addr == `CRC_ADDR_OPER && sfr_wdata[`CRC_OPER_START] && !cpu_hold;
    // codes 00 and 11 both scan the whole array
    scan_lim = (region_size == 2'h1 || region_size == 2'h2) ?
               (FAW+1)'(FLASH_BYTES - region_size * 1024) : (FAW+1)'(FLASH_BYTES);
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_rd_answer: assert property (sfr_rd |=> sfr_rd_valid)
    else $error("read strobe not answered next cycle");
  a_rd_cause: assert property (sfr_rd_valid |-> $past(sfr_rd))
    else $error("read data without a read strobe");
  a_byte_time: assert property (wr_data && !cpu_hold |=> cpu_hold[*8] ##[1:5] !cpu_hold)
    else $error("byte processing time out of bounds");
  a_hold_scan: assert property (fl_rd |-> cpu_hold)
    else $error("flash fetch while processor not held");
  a_fetch_gap: assert property (fl_rd |=> !fl_rd ##1 (fl_valid && !fl_rd))
    else $error("flash fetch handshake broken");
  a_scan_range: assert property (fl_rd |-> {1'b0, fl_addr} < scan_lim)
    else $error("flash fetch inside the app-writable area");
  a_scan_first: assert property (start && !boot_exec |-> ##[1:8] (fl_rd && fl_addr == '0))
    else $error("scan did not begin at address zero");
  a_boot_block: assert property (start && boot_exec |=> !fl_rd [*8])
    else $error("scan started from boot loader");

  c_scan_end: cover property (fl_rd && {1'b0, fl_addr} == scan_lim - 1'b1);
  c_boot: cover property (start && boot_exec);
  c_byte: cover property (wr_data && !cpu_hold);
endmodule // crc_link_props

// File: bench/tb_top.sv
// self-checking bench: host and engine ends joined through the link interface
`timescale 1ns/1ps
`include "crc_consts.svh"

`define CHK(g, e) cmp(32'(g), 32'(e));

module tb_top;
  localparam int FB  = 3072;
  localparam int FAW = $clog2(FB);
  logic           sys_clk_in, rstn_in, cmd_valid, cmd_write, cmd_rdy, rsp_valid;
  logic           boot, irq_en, held, busy, match;
  logic [7:0]     cmd_addr, cmd_wdata, rsp_data;
  logic [1:0]     region;
  logic [FAW-1:0] fl_a;
  logic [31:0]    ref_crc, word, crc_val, exp;
  logic [7:0]     mem [FB];
  logic [7:0]     eq[$];
  int             num_errors, checks, n_fetch, n_full, f0, w0, len;
  wire logic [7:0] fl_dat = mem[fl_a];

  crc_if #(.FAW(FAW)) bus ();
  crc_dev #(.FLASH_BYTES(FB)) crc_dev_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .bus(bus),
    .crc_value_out(crc_val), .scan_busy_out(busy));
  crc_host #(.FAW(FAW)) crc_host_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .bus(bus), .cmd_valid_in(cmd_valid),
    .cmd_write_in(cmd_write), .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .cmd_ready_out(cmd_rdy),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .boot_exec_in(boot), .region_size_in(region),
    .fl_addr_out(fl_a), .fl_rdata_in(fl_dat), .ref_crc_in(ref_crc), .result_word_out(word),
    .result_match_out(match), .global_irq_enable_out(irq_en), .held_out(held));
  crc_link_props #(.FAW(FAW), .FLASH_BYTES(FB)) crc_link_props_i (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd), .sfr_addr(bus.sfr_addr), .sfr_wdata(bus.sfr_wdata),
    .sfr_rd_valid(bus.sfr_rd_valid), .cpu_hold(bus.cpu_hold), .boot_exec(bus.boot_exec),
    .region_size(bus.region_size), .fl_rd(bus.fl_rd), .fl_addr(bus.fl_addr), .fl_valid(bus.fl_valid));

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
    for (int k = 7; k >= 0; k--) c = {c[30:0], 1'b0} ^ ((c[31] ^ b[k]) ? `CRC_POLY : 32'h0);
    return c;
  endfunction

  // request held from a falling edge until the edge that takes it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk_in);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr  = a;
    cmd_wdata = d;
    while (cmd_rdy !== 1'b1) begin
      @(negedge sys_clk_in);
      n++;
      if (n > 300) begin
        num_errors++;
        tally_and_finish();
      end
    end
    @(negedge sys_clk_in);
    cmd_valid = 1'b0;
  endtask

  task automatic read_res(input logic [31:0] e, input logic [1:0] ix);
    logic [1:0] k;
    acc(1'b1, `CRC_ADDR_INX, {6'h0, ix});
    for (int j = 0; j < 4; j++) begin
      k = ix + j[1:0];
      eq.push_back(e[8*k +: 8]);
      acc(1'b0, `CRC_ADDR_DATA, 8'h00);
    end
  endtask

  task automatic wait_hold(input logic lvl, input int lim);
    int n;
    n = 0;
    while (held !== lvl) begin
      @(negedge sys_clk_in);
      n++;
      if (n > lim) begin
        num_errors++;
        tally_and_finish();
      end
    end
  endtask

  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  // sampled mid-cycle so registered outputs have settled; also counts fetches and fifo-full cycles
  always @(negedge sys_clk_in) begin
    if (rsp_valid === 1'b1) `CHK(rsp_data, eq.pop_front())
    if (bus.fl_rd === 1'b1) n_fetch++;
    if (bus.data_ready === 1'b0) n_full++;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstn_in, cmd_valid, cmd_write, cmd_addr, cmd_wdata, boot, region, ref_crc} = '0;
    num_errors = 0;
    checks = 0;
    void'($urandom(23));
    // every byte written, as after a full erase, so no leftover content skews the scan
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rstn_in = 1'b1;
    acc(1'b1, `CRC_ADDR_OPER, 8'h02);
    read_res(32'hffffffff, 2'h0);
    for (int i = 0; i < 9; i++) acc(1'b1, `CRC_ADDR_DATA, 8'h31 + i[7:0]);
    exp = 32'h0376e6e7;
    ref_crc = exp;
    read_res(exp, 2'h2);
    eq.push_back(8'h02);
    acc(1'b0, `CRC_ADDR_INX, 8'h00);
    `CHK(crc_val, exp)
    read_res(exp, 2'h0);
    eq.push_back(8'h00);
    acc(1'b0, 8'h80, 8'h00);
    repeat (5) @(negedge sys_clk_in);
    `CHK(word, exp)
    `CHK(match, 1'b1)
    for (int r = 0; r < 4; r++) begin
      region = r[1:0];
      len    = (r == 1 || r == 2) ? FB - r * `CRC_KBYTE : FB;
      f0     = n_fetch;
      w0     = n_full;
      acc(1'b1, `CRC_ADDR_OPER, 8'h01);
      wait_hold(1'b1, 20);
      `CHK(irq_en, 1'b0)
      wait_hold(1'b0, 60000);
      `CHK(n_fetch - f0, len)
      `CHK(n_full > w0, 1'b1)
      `CHK(bus.data_ready, 1'b1)
      exp = 32'hffffffff;
      for (int a = 0; a < len; a++) exp = crc_upd(exp, mem[a]);
      read_res(exp, 2'h0);
      `CHK(irq_en, 1'b1)
    end
    boot = 1'b1;
    f0   = n_fetch;
    acc(1'b1, `CRC_ADDR_OPER, 8'h01);
    repeat (20) @(negedge sys_clk_in);
    `CHK(busy, 1'b0)
    `CHK(crc_val, exp)
    `CHK(n_fetch - f0, 0)
    boot = 1'b0;
    repeat (8) @(negedge sys_clk_in);
    `CHK(eq.size(), 0)
    tally_and_finish();
  end
endmodule // tb_top
